// ===== fot_defs.svh
// Constants of the fail-safe output test sequencer.
`ifndef FOT_DEFS_SVH
`define FOT_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FOT_A_CTRL    8'h00
`define FOT_A_CHCFG   8'h04
`define FOT_A_PROC    8'h08
`define FOT_A_ACK     8'h0c
`define FOT_A_STAT    8'h10
`define FOT_A_DIAG    8'h14
`define FOT_A_LAYOUT  8'h18
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FOT_B_MODPSV  0
`define FOT_B_REINT   1
`define FOT_B_PERLNG  3
`define FOT_B_DSUPP   4
`define FOT_B_NEWFAM  5
`define FOT_B_MANUAL  8
`define FOT_CTRL_RST  32'h0000_0008
`define FOT_CHCFG_RST 32'h0000_ff00
`define FOT_BYTES_OLD 32'h0000_0005
`define FOT_BYTES_NEW 32'h0000_0006
// ----------------------------------------------------------------
// Times in their own units
// ----------------------------------------------------------------
`define FOT_CLK_MHZ     100
`define FOT_MS_US       1000
`define FOT_PER_SHORT_S 100
`define FOT_PER_LONG_S  1000
`define FOT_PER_FAULT_S 60
`define FOT_SUPP_H      48
`define FOT_GAP_MS      500
`define FOT_RB_LF_US    800
`define FOT_RB_DF_US    1000
`define FOT_RB_LS_US    3000
`define FOT_RB_DS_US    5000
`endif

// ===== fot_pkg.sv
// Types shared by the fail-safe output test sequencer.
`default_nettype none
package fot_pkg;
   // Reintegration choice for the whole module.
   typedef enum logic [1:0] {
      FOT_RI_ADJ  = 2'b00,
      FOT_RI_AUTO = 2'b01,
      FOT_RI_MAN  = 2'b10
   } fot_reint_t;
   // Test sequencer states, Gray coded along the loop.
   typedef enum logic [1:0] {
      FOT_ST_IDLE  = 2'b00,
      FOT_ST_GAP   = 2'b01,
      FOT_ST_PULSE = 2'b11,
      FOT_ST_EVAL  = 2'b10
   } fot_state_t;
   // Module configuration as software writes it.
   typedef struct packed {
      logic       new_family;
      logic       dark_supp;
      logic       period_long;
      fot_reint_t reint;
      logic       mod_passivate;
   } fot_cfg_t;
endpackage
`default_nettype wire

// ===== fot_seq.sv
// Test sequencer and fault reaction of an eight-channel fail-safe output.
`timescale 1ns/1ps
`default_nettype none
`include "fot_defs.svh"
module fot_seq #(
   parameter int NCH      = 8,
   parameter int MS_CYC   = `FOT_MS_US * `FOT_CLK_MHZ,
   parameter int RB_LF    = `FOT_RB_LF_US * MS_CYC / `FOT_MS_US,
   parameter int RB_DF    = `FOT_RB_DF_US * MS_CYC / `FOT_MS_US,
   parameter int RB_LS    = `FOT_RB_LS_US * MS_CYC / `FOT_MS_US,
   parameter int RB_DS    = `FOT_RB_DS_US * MS_CYC / `FOT_MS_US,
   parameter int PER_S_MS = `FOT_PER_SHORT_S * 1000,
   parameter int PER_L_MS = `FOT_PER_LONG_S * 1000,
   parameter int PER_F_MS = `FOT_PER_FAULT_S * 1000,
   parameter int SUPP_MS  = `FOT_SUPP_H * 3600 * 1000,
   parameter int GAP_MS   = `FOT_GAP_MS
) (
   // Clock and reset.
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // Output switches and their readback pins.
   output var  logic [NCH-1:0]    out_drive,
   input  wire logic [NCH-1:0]    readback,
   // Diagnostic alarm level.
   output var  logic              diag_alarm
);
   import fot_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // One-hot mask of a channel index.
   function automatic logic [NCH-1:0] onehot(input logic [2:0] c);
      logic [NCH-1:0] m;
      m    = '0;
      m[c] = 1'b1;
      return m;
   endfunction

   // Readback limit in cycles for a slow flag and a test kind.
   function automatic logic [31:0] rb_lim(input logic slow, input logic dark);
      logic [31:0] v;
      v = 32'(RB_LF);
      if (slow && dark) begin
         v = 32'(RB_DS);
      end else if (slow) begin
         v = 32'(RB_LS);
      end else if (dark) begin
         v = 32'(RB_DF);
      end
      return v;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   fot_cfg_t       cfg_q;
   logic [NCH-1:0] slow_q, man_q, proc_q, app_q, psv_q, rdy_q;
   logic [NCH-1:0] short_q, shut_q, rb_s1, rb_s2, sd_mask_q;
   logic [NCH-1:0] out_q;
   logic           xc_q, alarm_q, fault_q, cyc_fault_q, retry_q;
   logic           start_q, fail_q, pol_q, pready_q, pslverr_q;
   logic [31:0]    prdata_q, ms_cnt_q, per_cnt_q, supp_cnt_q;
   logic [31:0]    gap_cnt_q, tmr_q, sd_tmr_q;
   logic [2:0]     ch_q;
   fot_state_t     st_q;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Every access takes one wait state so that pready comes from a flop.
   wire            acc     = psel && penable && !pready_q;
   // Writes commit at the completing edge, while pready stands high.
   wire            wr      = psel && penable && pready_q && pwrite;
   wire            a_ctrl  = paddr == `FOT_A_CTRL;
   wire            a_chcfg = paddr == `FOT_A_CHCFG;
   wire            a_proc  = paddr == `FOT_A_PROC;
   wire            a_ack   = paddr == `FOT_A_ACK;
   wire            a_stat  = paddr == `FOT_A_STAT;
   wire            a_diag  = paddr == `FOT_A_DIAG;
   wire            a_lay   = paddr == `FOT_A_LAYOUT;
   wire            mapped  = a_ctrl | a_chcfg | a_proc | a_ack | a_stat
                             | a_diag | a_lay;
   wire [NCH-1:0]  ack_w   = (wr && a_ack) ? pwdata[NCH-1:0] : '0;
   wire [NCH-1:0]  dclr_s  = (wr && a_diag) ? pwdata[NCH-1:0] : '0;
   wire [NCH-1:0]  dclr_f  = (wr && a_diag) ? pwdata[15:8] : '0;
   wire            xclr    = wr && a_diag && pwdata[16];
   wire [31:0]     lay_v   = cfg_q.new_family ? `FOT_BYTES_NEW
                                              : `FOT_BYTES_OLD;
   wire [31:0]     rd_v    =
      a_ctrl  ? {26'h0, cfg_q} :
      a_chcfg ? {16'h0, man_q, slow_q} :
      a_proc  ? {24'h0, proc_q} :
      a_stat  ? {12'h0, st_q, retry_q, alarm_q, rdy_q, ~psv_q} :
      a_diag  ? {15'h0, xc_q, shut_q, short_q} :
      a_lay   ? lay_v : 32'h0;

   // Bus answer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc && !mapped;
         prdata_q  <= (acc && !pwrite) ? rd_v : 32'h0;
      end
   end

   // Configuration and process image writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q  <= fot_cfg_t'(6'(`FOT_CTRL_RST));
         slow_q <= NCH'(`FOT_CHCFG_RST);
         man_q  <= NCH'(`FOT_CHCFG_RST >> `FOT_B_MANUAL);
         proc_q <= '0;
      end else if (wr) begin
         if (a_ctrl) begin
            cfg_q <= fot_cfg_t'(pwdata[5:0]);
         end
         if (a_chcfg) begin
            slow_q <= pwdata[NCH-1:0];
            man_q  <= pwdata[15:8];
         end
         if (a_proc) begin
            proc_q <= pwdata[NCH-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Readback synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rb_s1 <= '0;
         rb_s2 <= '0;
      end else begin
         rb_s1 <= readback;
         rb_s2 <= rb_s1;
      end
   end

   // ----------------------------------------------------------------
   // Period, suppression and reintegration terms
   // ----------------------------------------------------------------
   // Channel 0 slow flag stands for all under dark suppression.
   wire            slow_c  = cfg_q.dark_supp ? slow_q[0] : slow_q[ch_q];
   wire            ms_tick = ms_cnt_q == 32'(MS_CYC - 1);
   wire [31:0]     per_lim = fault_q ? 32'(PER_F_MS) :
                             cfg_q.period_long ? 32'(PER_L_MS)
                                               : 32'(PER_S_MS);
   wire            per_exp = ms_tick && per_cnt_q >= per_lim - 32'h1;
   wire            supp_exp = supp_cnt_q >= 32'(SUPP_MS);
   wire            dark_en = !cfg_q.dark_supp || supp_exp;
   wire [NCH-1:0]  base    = app_q & ~psv_q;
   wire            cur     = base[ch_q];
   // A dark test is skipped while suppressed; light tests always run.
   wire            do_test = !cur || dark_en;
   wire            sd_busy = sd_tmr_q != 32'h0;
   wire            gap_end = gap_cnt_q >= 32'(GAP_MS) && !sd_busy;
   wire [31:0]     lim     = rb_lim(slow_c, pol_q);
   wire            rb_ok   = rb_s2[ch_q] == !pol_q;
   wire            cyc_end = st_q == FOT_ST_EVAL && ch_q == 3'(NCH - 1)
                             && !(fail_q && !pol_q && !retry_q);
   // Shutdown requests of channels that are on now.
   wire [NCH-1:0]  falls   = base & ~proc_q;
   wire            new_app = st_q != FOT_ST_PULSE;
   wire            xc_det  = sd_tmr_q == 32'h1 && |(rb_s2 & sd_mask_q);
   // Effective manual flag per channel.
   wire [NCH-1:0]  man_v   =
      cfg_q.reint == FOT_RI_MAN  ? {NCH{1'b1}} :
      cfg_q.reint == FOT_RI_AUTO ? {NCH{1'b0}} :
      cfg_q.mod_passivate ? {NCH{man_q[0]}} : man_q;
   wire [NCH-1:0]  psv_clr = rdy_q & (~man_v | ack_w);
   // Fault sources of the evaluation step and of the cross circuit check.
   wire            ev_fail = st_q == FOT_ST_EVAL && fail_q;
   wire            dk_fail = ev_fail && pol_q;
   wire            lt_fail = ev_fail && !pol_q;
   wire [NCH-1:0]  psv_ch  = lt_fail ? onehot(ch_q) : '0;
   wire            psv_all = dk_fail || xc_det ||
                             (cfg_q.mod_passivate && lt_fail);
   wire [NCH-1:0]  psv_set = psv_all ? {NCH{1'b1}} : psv_ch;
   wire            any_f   = ev_fail || xc_det;

   // Millisecond prescaler, period and suppression counters.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_q   <= 32'h0;
         per_cnt_q  <= 32'h0;
         supp_cnt_q <= 32'h0;
         start_q    <= 1'b1;
      end else begin
         ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
         if (per_exp) begin
            per_cnt_q <= 32'h0;
         end else if (ms_tick) begin
            per_cnt_q <= per_cnt_q + 32'h1;
         end
         // All outputs at 0 together restart the suppression window.
         if (app_q == '0) begin
            supp_cnt_q <= 32'h0;
         end else if (ms_tick && !supp_exp) begin
            supp_cnt_q <= supp_cnt_q + 32'h1;
         end
         if (per_exp) begin
            start_q <= 1'b1;
         end else if (st_q == FOT_ST_IDLE) begin
            start_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Test sequencer
   // ----------------------------------------------------------------
   // Pulses go out only inside a cycle, one gap apart.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= FOT_ST_IDLE;
         ch_q      <= 3'h0;
         gap_cnt_q <= 32'h0;
         tmr_q     <= 32'h0;
         fail_q    <= 1'b0;
         pol_q     <= 1'b0;
      end else begin
         case (st_q)
            FOT_ST_IDLE: begin
               if (start_q) begin
                  ch_q      <= 3'h0;
                  gap_cnt_q <= 32'h0;
                  st_q      <= FOT_ST_GAP;
               end
            end
            FOT_ST_GAP: begin
               if (ms_tick && gap_cnt_q < 32'(GAP_MS)) begin
                  gap_cnt_q <= gap_cnt_q + 32'h1;
               end
               if (gap_end && do_test) begin
                  pol_q <= cur;
                  tmr_q <= 32'h0;
                  st_q  <= FOT_ST_PULSE;
               end else if (gap_end) begin
                  fail_q <= 1'b0;
                  pol_q  <= 1'b1;
                  st_q   <= FOT_ST_EVAL;
               end
            end
            FOT_ST_PULSE: begin
               tmr_q <= tmr_q + 32'h1;
               if (rb_ok) begin
                  fail_q <= 1'b0;
                  st_q   <= FOT_ST_EVAL;
               end else if (tmr_q >= lim - 32'h1) begin
                  fail_q <= 1'b1;
                  st_q   <= FOT_ST_EVAL;
               end
            end
            FOT_ST_EVAL: begin
               gap_cnt_q <= 32'h0;
               if (fail_q && !pol_q && !retry_q) begin
                  st_q <= FOT_ST_GAP;
               end else if (ch_q == 3'(NCH - 1)) begin
                  st_q <= FOT_ST_IDLE;
               end else begin
                  ch_q <= ch_q + 3'h1;
                  st_q <= FOT_ST_GAP;
               end
            end
            default: begin
               st_q <= FOT_ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Fault reaction and reintegration
   // ----------------------------------------------------------------
   // Hardware sets win over software clears in every flag here.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psv_q       <= '0;
         rdy_q       <= '0;
         short_q     <= '0;
         shut_q      <= '0;
         xc_q        <= 1'b0;
         alarm_q     <= 1'b0;
         fault_q     <= 1'b0;
         cyc_fault_q <= 1'b0;
         retry_q     <= 1'b0;
      end else begin
         psv_q <= (psv_q & ~psv_clr) | psv_set;
         if (dk_fail) begin
            short_q <= (short_q & ~dclr_s) | onehot(ch_q);
            shut_q  <= (shut_q & ~dclr_f) | ~onehot(ch_q);
         end else begin
            short_q <= short_q & ~dclr_s;
            shut_q  <= shut_q & ~dclr_f;
         end
         xc_q <= xc_det || (xc_q && !xclr);
         if (lt_fail && !retry_q) begin
            retry_q <= 1'b1;
         end else if (st_q == FOT_ST_EVAL) begin
            retry_q <= 1'b0;
         end
         if (lt_fail && retry_q) begin
            alarm_q <= 1'b1;
         end else if (cyc_end && !cyc_fault_q) begin
            alarm_q <= 1'b0;
         end
         if (any_f) begin
            fault_q     <= 1'b1;
            cyc_fault_q <= 1'b1;
         end else if (cyc_end) begin
            cyc_fault_q <= 1'b0;
            if (!cyc_fault_q) begin
               fault_q <= 1'b0;
            end
         end
         // A clean cycle marks ready what was passivated before it.
         if (any_f) begin
            rdy_q <= rdy_q & ~psv_set & ~psv_clr;
         end else if (cyc_end && !cyc_fault_q) begin
            rdy_q <= psv_q & ~psv_clr;
         end else begin
            rdy_q <= rdy_q & ~psv_clr;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output image and drive
   // ----------------------------------------------------------------
   // Channels cannot be disabled; each is driven from the process image unless passivated or under test.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         app_q     <= '0;
         sd_tmr_q  <= 32'h0;
         sd_mask_q <= '0;
         out_q     <= '0;
      end else begin
         if (new_app) begin
            app_q <= proc_q;
         end
         if (new_app && |falls) begin
            sd_tmr_q  <= rb_lim(slow_c, 1'b1);
            sd_mask_q <= falls;
         end else if (sd_busy) begin
            sd_tmr_q <= sd_tmr_q - 32'h1;
         end
         if (st_q == FOT_ST_PULSE) begin
            out_q <= base ^ onehot(ch_q);
         end else begin
            out_q <= base & ~psv_set;
         end
      end
   end

   assign out_drive  = out_q;
   assign diag_alarm = alarm_q;
   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_psv_off: assert property ($past(st_q) != FOT_ST_PULSE |->
      (out_q & $past(psv_q)) == '0) else $error("passivated output on");
   chk_proc_hold: assert property (st_q == FOT_ST_PULSE |=>
      app_q == $past(app_q)) else $error("process value during pulse");
   chk_dark_all: assert property (dk_fail |=> &psv_q &&
      short_q[$past(ch_q)]) else $error("dark error not module wide");
   chk_mod_psv: assert property (cfg_q.mod_passivate && |psv_set |=>
      &psv_q) else $error("module passivation missed");
   chk_rb_limit: assert property (st_q == FOT_ST_PULSE |->
      tmr_q < 32'(RB_DS)) else $error("readback beyond 5 ms");
   chk_fault_per: assert property (fault_q |-> per_lim ==
      32'(PER_F_MS)) else $error("fault period not 60 s");
   chk_light_rep: assert property (lt_fail && !retry_q |=>
      st_q == FOT_ST_GAP && retry_q && ch_q == $past(ch_q))
      else $error("light retry missing");
   chk_light_alm: assert property (lt_fail && retry_q |=> alarm_q
      && fault_q) else $error("no alarm on second failure");
   chk_pulse_drv: assert property (st_q == FOT_ST_PULSE |=>
      out_q[$past(ch_q)] == !$past(pol_q)) else $error("pulse level wrong");
   chk_man_hold: assert property (ack_w == '0 |=>
      ($past(psv_q & man_v) & ~psv_q) == '0)
      else $error("manual channel freed without ack");
   chk_xc_all: assert property (xc_det |=> &psv_q ##0 xc_q)
      else $error("cross circuit not module wide");

   cov_dark: cover property (st_q == FOT_ST_PULSE && pol_q);
   cov_retry: cover property (lt_fail ##[1:1000] st_q == FOT_ST_PULSE);
   cov_reint: cover property (|psv_q ##1 psv_q == '0);
   cov_xc: cover property (xc_det);
endmodule // fot_seq
`default_nettype wire

// ===== fot_load_model.sv
// Load and readback model that stands at the output pins of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module fot_load_model (
   // Drive from the sequencer.
   input  wire logic [7:0] out_drive,
   // Fault injection, readback stuck low or high per channel.
   input  wire logic [7:0] stuck_lo,
   input  wire logic [7:0] stuck_hi,
   // Readback pins back to the sequencer.
   output var  logic [7:0] readback
);
   // A healthy load follows its drive at once; a fault pins the line.
   assign readback = (out_drive & ~stuck_lo) | stuck_hi;
endmodule // fot_load_model
`default_nettype wire

// ===== tb.sv
// Self-checking testbench of the fail-safe output test sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "fot_defs.svh"
module tb;
   import fot_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, diag_alarm, err;
   logic [7:0]  out_drive, readback;
   logic [7:0]  stuck_lo = 8'h00;
   logic [7:0]  stuck_hi = 8'h00;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cnt;
   // Short counts keep the run small: 10 cycles stand for one ms.
   fot_seq #(.MS_CYC(10), .PER_L_MS(300), .PER_F_MS(100), .SUPP_MS(50), .GAP_MS(2))
   fot_seq_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .out_drive(out_drive),
      .readback(readback), .diag_alarm(diag_alarm));
   fot_load_model fot_load_model_inst (.out_drive(out_drive), .stuck_lo(stuck_lo),
      .stuck_hi(stuck_hi), .readback(readback));
   // Free-running 100 MHz clock.
   always #5 pclk = ~pclk;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h", $time, m, got);
      end
   endtask
   task automatic end_of_test();
      $display("Counts: %0d compares, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         $display("MISMATCH %0t no bus answer", $time);
         end_of_test();
      end
   endtask
   // Reads until the masked value matches; a stale value then fails its check.
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0000_0000);
         n++;
      end while ((rd & m) !== e && n < 400);
   endtask
   // Waits, bounded, until the drive leaves the value given.
   task automatic wait_chg(input logic [7:0] v);
      cnt = 0;
      do begin
         @(posedge pclk);
         cnt++;
      end while (out_drive === v && cnt < 5000);
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      // Light pulses run channel by channel; channel 3 reads back stuck low.
      stuck_lo <= 8'h08;
      do_reset();
      wait_chg(8'h00);
      chk(out_drive, 8'h01, "first light pulse");
      wait_chg(8'h01);
      wait_chg(8'h00);
      chk(out_drive, 8'h02, "second light pulse");
      chk(cnt >= 15, 1'b1, "pulse spacing");
      poll(`FOT_A_STAT, 32'h0000_00ff, 32'h0000_00f7);
      chk(rd[7:0], 8'hf7, "light fail passivates one");
      poll(`FOT_A_STAT, 32'h0001_0000, 32'h0001_0000);
      chk(diag_alarm, 1'b1, "alarm after repeat");
      $display("Test light_fail done");
      // Reset values, layout and an unmapped offset.
      do_reset();
      apb(1'b0, `FOT_A_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0008, "ctrl reset");
      apb(1'b0, `FOT_A_CHCFG, 32'h0000_0000);
      chk(rd, 32'h0000_ff00, "chcfg reset");
      apb(1'b0, `FOT_A_LAYOUT, 32'h0000_0000);
      chk(rd, 32'h0000_0005, "old layout");
      apb(1'b1, `FOT_A_CTRL, 32'h0000_0028);
      apb(1'b0, `FOT_A_LAYOUT, 32'h0000_0000);
      chk(rd, 32'h0000_0006, "new layout");
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped read data");
      chk(err, 1'b1, "unmapped read error");
      $display("Test registers done");
      // Dark test with channel 2 stuck high shuts the module down.
      stuck_lo <= 8'h00;
      stuck_hi <= 8'h04;
      do_reset();
      apb(1'b1, `FOT_A_PROC, 32'h0000_00ff);
      poll(`FOT_A_STAT, 32'h0000_00ff, 32'h0000_0000);
      chk(rd[7:0], 8'h00, "dark fail passivates all");
      apb(1'b0, `FOT_A_DIAG, 32'h0000_0000);
      chk(rd[15:0], 16'hfb04, "dark fail diagnosis");
      chk(out_drive, 8'h00, "all outputs off");
      $display("Test dark_fail done");
      // Light fail under module passivation; manual channels wait for acknowledge.
      stuck_hi <= 8'h00;
      stuck_lo <= 8'h08;
      do_reset();
      apb(1'b1, `FOT_A_CTRL, 32'h0000_0009);
      poll(`FOT_A_STAT, 32'h0000_00ff, 32'h0000_0000);
      chk(rd[7:0], 8'h00, "light fail passivates module");
      stuck_lo <= 8'h00;
      poll(`FOT_A_STAT, 32'h0000_ff00, 32'h0000_ff00);
      chk(rd[15:0], 16'hff00, "ready but held for acknowledge");
      apb(1'b1, `FOT_A_ACK, 32'h0000_00ff);
      apb(1'b0, `FOT_A_STAT, 32'h0000_0000);
      chk(rd[7:0], 8'hff, "acknowledge reintegrates");
      $display("Test module_passivation done");
      // Dark pulses wait out the suppression window; a stuck line on shutdown is a cross circuit.
      do_reset();
      apb(1'b1, `FOT_A_CTRL, 32'h0000_0018);
      apb(1'b1, `FOT_A_PROC, 32'h0000_00ff);
      wait_chg(8'h00);
      wait_chg(8'hff);
      chk(cnt >= 500, 1'b1, "dark pulses suppressed");
      chk(out_drive, 8'hfe, "dark pulse after window");
      stuck_hi <= 8'h20;
      apb(1'b1, `FOT_A_PROC, 32'h0000_0000);
      poll(`FOT_A_DIAG, 32'h0001_0000, 32'h0001_0000);
      chk(rd[16], 1'b1, "cross circuit flagged");
      apb(1'b0, `FOT_A_STAT, 32'h0000_0000);
      chk(rd[7:0], 8'h00, "cross circuit passivates module");
      $display("Test cross_circuit done");
      end_of_test();
   end
endmodule // tb
`default_nettype wire
